// ===== hw/sirc_pkg.sv
// sirc_pkg: shared constants, register map and field layouts for the serial receiver
// with infrared codec. Assumes a single 250 MHz system clock.
package sirc_pkg;
  // register indices on the plain register port
  localparam logic [3:0] SIRC_ADDR_BAUD = 4'h0;   // baud divisor, 32x rate
  localparam logic [3:0] SIRC_ADDR_CTRL = 4'h1;   // control
  localparam logic [3:0] SIRC_ADDR_STAT = 4'h2;   // status, write one to clear
  localparam logic [3:0] SIRC_ADDR_DATA = 4'h3;   // receive data (read clears full)
  localparam logic [3:0] SIRC_ADDR_TXD = 4'h4;    // transmit data
  // control field positions
  localparam int SIRC_CTRL_IR_EN = 0;
  localparam int SIRC_CTRL_TX_PULSE_POLARITY = 1;
  localparam int SIRC_CTRL_RX_PULSE_POLARITY = 2;
  localparam int SIRC_CTRL_NINE = 3;
  localparam int SIRC_CTRL_RIE = 4;
  localparam int SIRC_CTRL_WID_LO = 5;            // two bits: pulse width select
  localparam int SIRC_CTRL_TX_CANCEL = 7;
  localparam int SIRC_CTRL_RX_EN = 8;
  // status field positions
  localparam int SIRC_STAT_FULL = 0;
  localparam int SIRC_STAT_NOISE = 1;
  localparam int SIRC_STAT_BREAK = 2;
  localparam int SIRC_STAT_COLL = 3;
  localparam int SIRC_STAT_TXBUSY = 4;
  localparam int SIRC_STAT_RXBUSY = 5;
  // reset values
  localparam logic [15:0] SIRC_BAUD_RST = 16'h0001;
  localparam logic [8:0] SIRC_CTRL_RST = 9'h100;
  // sample positions within a bit (16 ticks per bit)
  localparam logic [3:0] SIRC_RT3 = 4'h3;
  localparam logic [3:0] SIRC_RT5 = 4'h5;
  localparam logic [3:0] SIRC_RT7 = 4'h7;
  localparam logic [3:0] SIRC_RT8 = 4'h8;
  localparam logic [3:0] SIRC_RT9 = 4'h9;
  localparam logic [3:0] SIRC_RT10 = 4'ha;
  localparam logic [3:0] SIRC_RT_LAST = 4'hf;
  // pulse width select codes
  localparam logic [1:0] SIRC_WID_1_32 = 2'h0;
  localparam logic [1:0] SIRC_WID_1_16 = 2'h1;
  localparam logic [1:0] SIRC_WID_3_16 = 2'h2;
  localparam logic [1:0] SIRC_WID_1_4 = 2'h3;

  // register port request bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } sirc_bus_req_t;

  // receiver states, gray along start, data, stop
  typedef enum logic [1:0] {
    SIRC_RX_IDLE = 2'b00,
    SIRC_RX_START = 2'b01,
    SIRC_RX_DATA = 2'b11,
    SIRC_RX_STOP = 2'b10
  } sirc_rx_state_t;
endpackage : sirc_pkg

// ===== hw/sirc_baud_gen.sv
// sirc_baud_gen: divides the system clock into 32x and 16x baud enable pulses.
// Assumes the divisor is at least one; the 16x pulse is every second 32x pulse.
`timescale 1ns/100ps
`default_nettype none
module sirc_baud_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // divisor in system clocks per 32x tick
  input wire logic [15:0] divisor,
  // restart phase of the 16x tick
  input wire logic resync,
  // enables
  output logic tick32,
  output logic tick16
);
  import sirc_pkg::*;
  logic [15:0] cnt_reg;
  logic half_reg;

  // divider counts down, one-cycle pulse on wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      tick32 <= 1'b0;
    end else if (cnt_reg == 16'h0000) begin
      cnt_reg <= divisor - 16'h0001;
      tick32 <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
      tick32 <= 1'b0;
    end
  end

  // every second 32x pulse gives the 16x pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      half_reg <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      tick16 <= (cnt_reg == 16'h0000) && half_reg;
      if (resync) begin
        half_reg <= 1'b0;
      end else if (cnt_reg == 16'h0000) begin
        half_reg <= ~half_reg;
      end
    end
  end
endmodule : sirc_baud_gen
`default_nettype wire

// ===== hw/sirc_top.sv
// sirc_top: serial receiver with infrared return-to-zero encoder and decoder.
// Assumes pins synchronous to clk_sys and a master that never waits.
// How it works
// - ir on: zero bit sends narrow pulse
// - pulse centred, width 1/32 1/16 3/16 1/4
// - tx polarity clear high, set low
// - rx polarity picks pulse level meaning zero
// - narrow rx pulses stretched to full bits
// - 32x tick times tx pulses
// - rx decoder uses only 16x tick
// - nrz normally, return-to-zero with ir
// - eight or nine data bits selectable
// - ninth bit in high data byte
// - data register loaded only from shifter
// - frame done: load data, set full
// - full and enable raise interrupt request
// - line sampled at sixteen times baud
// - resync after start and one-to-zero change
// - start search: zero after three ones
// - falling edge starts sixteen count
// - verify start at samples 3 5 7
// - break character detected
// - tx/rx collision detect in nrz only, tx cancel
// - two of three zeros accept, disagree noise
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sirc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire sirc_pkg::sirc_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  // line pins
  input wire logic rx_pin,
  output logic tx_pin,
  // interrupt request level
  output logic rx_irq
);
  import sirc_pkg::*;

  logic [15:0] baud_reg;
  logic [8:0] ctrl_reg;
  logic tick32;
  logic tick16;
  logic rx_resync;
  logic ir_en;
  logic [1:0] wid;
  logic [8:0] rx_data_reg;
  logic full_reg;
  logic noise_reg;
  logic break_reg;
  logic coll_reg;
  sirc_rx_state_t rx_state_reg;
  logic [3:0] rt_reg;
  logic [3:0] bitn_reg;
  logic [9:0] shift_reg;
  logic [2:0] hist_reg;
  logic s3_reg, s5_reg, s8_reg, s9_reg;
  logic prev_bit_reg;
  logic rx_bit;
  logic rx_stretch_reg;
  logic [4:0] str_cnt_reg;
  logic tx_busy_reg;
  logic [11:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [4:0] tx_ph_reg;
  logic tx_level;
  logic vote;
  logic frame_done;
  logic rd_data_hit;
  logic last_smp_reg;
  logic data_fall;

  assign ir_en = ctrl_reg[SIRC_CTRL_IR_EN];
  assign wid = ctrl_reg[SIRC_CTRL_WID_LO +: 2];
  assign rd_data_hit = bus_req.rd && (bus_req.addr == SIRC_ADDR_DATA);

  // baud ticks; 32x rate for tx pulses, 16x rate for rx
  sirc_baud_gen u_baud (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .divisor(baud_reg),
    .resync(rx_resync),
    .tick32(tick32),
    .tick16(tick16)
  );

  // register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      baud_reg <= SIRC_BAUD_RST;
      ctrl_reg <= SIRC_CTRL_RST;
    end else if (bus_req.wr && bus_req.addr == SIRC_ADDR_BAUD) begin
      baud_reg <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == SIRC_ADDR_CTRL) begin
      ctrl_reg <= bus_req.wdata[8:0];
    end
  end

  // read mux, data one cycle after strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        SIRC_ADDR_BAUD: bus_rdata <= baud_reg;
        SIRC_ADDR_CTRL: bus_rdata <= {7'h00, ctrl_reg};
        SIRC_ADDR_STAT: bus_rdata <= {10'h000, rx_state_reg != SIRC_RX_IDLE, tx_busy_reg,
                                      coll_reg, break_reg, noise_reg, full_reg};
        // ninth bit sits at bit 8
        SIRC_ADDR_DATA: bus_rdata <= {7'h00, rx_data_reg};
        default: bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // pulse stretcher: a zero pulse holds line low for one bit (16 ticks)
  // timed only by the 16x tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_stretch_reg <= 1'b1;
      str_cnt_reg <= 5'h00;
    end else if (tick16) begin
      // pulse level selected by rx polarity
      if ((rx_pin ^ ctrl_reg[SIRC_CTRL_RX_PULSE_POLARITY]) == 1'b1) begin
        rx_stretch_reg <= 1'b0;
        str_cnt_reg <= 5'h10;
      end else if (str_cnt_reg != 5'h00) begin
        str_cnt_reg <= str_cnt_reg - 5'h01;
      end else begin
        rx_stretch_reg <= 1'b1;
      end
    end
  end

  // nrz line straight, or stretched rz line with ir on
  assign rx_bit = ir_en ? rx_stretch_reg : rx_pin;

  // majority of samples 8, 9, 10
  assign vote = (s8_reg & s9_reg) | (s8_reg & rx_bit) | (s9_reg & rx_bit);
  assign frame_done = (rx_state_reg == SIRC_RX_STOP) && tick16 && rt_reg == SIRC_RT10;
  // resync at start edge and at a one-to-zero data change
  // falling line after a one bit, away from the vote samples
  assign data_fall = (rx_state_reg == SIRC_RX_DATA) && tick16 && prev_bit_reg && last_smp_reg
                     && !rx_bit && (rt_reg < SIRC_RT8 || rt_reg > SIRC_RT10);
  assign rx_resync = (rx_state_reg == SIRC_RX_IDLE && tick16 && hist_reg == 3'b111 && !rx_bit)
                  || data_fall;

  // receiver sequencer
  // every step on the 16x tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg <= SIRC_RX_IDLE;
      rt_reg <= 4'h0;
      bitn_reg <= 4'h0;
      shift_reg <= 10'h000;
      hist_reg <= 3'b000;
      s3_reg <= 1'b1;
      s5_reg <= 1'b1;
      s8_reg <= 1'b1;
      s9_reg <= 1'b1;
      prev_bit_reg <= 1'b1;
      last_smp_reg <= 1'b1;
    end else if (!ctrl_reg[SIRC_CTRL_RX_EN]) begin
      rx_state_reg <= SIRC_RX_IDLE;
      hist_reg <= 3'b000;
    end else if (tick16) begin
      rt_reg <= rt_reg + 4'h1;
      last_smp_reg <= rx_bit;
      if (rt_reg == SIRC_RT8) s8_reg <= rx_bit;
      if (rt_reg == SIRC_RT9) s9_reg <= rx_bit;
      case (rx_state_reg)
        SIRC_RX_IDLE: begin
          hist_reg <= {hist_reg[1:0], rx_bit};
          // zero after three ones starts count
          if (hist_reg == 3'b111 && !rx_bit) begin
            rx_state_reg <= SIRC_RX_START;
            rt_reg <= 4'h2;
          end
        end
        SIRC_RX_START: begin
          if (rt_reg == SIRC_RT3) s3_reg <= rx_bit;
          if (rt_reg == SIRC_RT5) s5_reg <= rx_bit;
          if (rt_reg == SIRC_RT7) begin
            // two of three zeros accept, else search again
            if ((s3_reg & s5_reg) | (s3_reg & rx_bit) | (s5_reg & rx_bit)) begin
              rx_state_reg <= SIRC_RX_IDLE;
              hist_reg <= 3'b000;
            end
          end
          if (rt_reg == SIRC_RT_LAST) begin
            rx_state_reg <= SIRC_RX_DATA;
            bitn_reg <= 4'h0;
            prev_bit_reg <= 1'b0;
          end
        end
        SIRC_RX_DATA: begin
          if (data_fall) rt_reg <= 4'h2;
          if (rt_reg == SIRC_RT10) begin
            shift_reg <= {vote, shift_reg[9:1]};
            prev_bit_reg <= vote;
            if (bitn_reg == (ctrl_reg[SIRC_CTRL_NINE] ? 4'h8 : 4'h7)) begin
              rx_state_reg <= SIRC_RX_STOP;
            end
            bitn_reg <= bitn_reg + 4'h1;
          end
        end
        SIRC_RX_STOP: begin
          if (rt_reg == SIRC_RT10) begin
            rx_state_reg <= SIRC_RX_IDLE;
            hist_reg <= 3'b000;
          end
        end
        default: rx_state_reg <= SIRC_RX_IDLE;
      endcase
    end
  end

  // data register loaded only from shifter at frame end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_reg <= 9'h000;
    end else if (frame_done) begin
      rx_data_reg <= ctrl_reg[SIRC_CTRL_NINE] ? shift_reg[9:1] : {1'b0, shift_reg[9:2]};
    end
  end

  // status flags: set wins over clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      full_reg <= 1'b0;
      noise_reg <= 1'b0;
      break_reg <= 1'b0;
    end else begin
      // full set at frame end, read of data clears it
      if (frame_done) full_reg <= 1'b1;
      else if (rd_data_hit) full_reg <= 1'b0;
      // noise only on an accepted start whose samples disagree
      if (rx_state_reg == SIRC_RX_START && tick16 && rt_reg == SIRC_RT7
          && !((s3_reg == s5_reg) && (s5_reg == rx_bit))
          && !((s3_reg & s5_reg) | (s3_reg & rx_bit) | (s5_reg & rx_bit))) noise_reg <= 1'b1;
      else if (bus_req.wr && bus_req.addr == SIRC_ADDR_STAT && bus_req.wdata[SIRC_STAT_NOISE])
        noise_reg <= 1'b0;
      // break: all data zero and stop bit zero
      if (frame_done && !vote
          && (ctrl_reg[SIRC_CTRL_NINE] ? shift_reg[9:1] == 9'h000 : shift_reg[9:2] == 8'h00))
        break_reg <= 1'b1;
      else if (bus_req.wr && bus_req.addr == SIRC_ADDR_STAT && bus_req.wdata[SIRC_STAT_BREAK])
        break_reg <= 1'b0;
    end
  end

  // interrupt level from full and enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) rx_irq <= 1'b0;
    else rx_irq <= (full_reg | frame_done) & ctrl_reg[SIRC_CTRL_RIE];
  end

  // transmit shifter, 32 phases of 32x tick per bit; a one-phase idle lead
  // puts every bit edge on a 32x tick so all bits have the same length
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 12'hfff;
      tx_left_reg <= 4'h0;
      tx_ph_reg <= 5'h00;
    end else if (bus_req.wr && bus_req.addr == SIRC_ADDR_TXD && !tx_busy_reg) begin
      tx_busy_reg <= 1'b1;
      // stop bit follows the last data bit of the selected length
      if (ctrl_reg[SIRC_CTRL_NINE]) tx_sh_reg <= {1'b1, bus_req.wdata[8:0], 1'b0, 1'b1};
      else tx_sh_reg <= {2'b11, bus_req.wdata[7:0], 1'b0, 1'b1};
      tx_left_reg <= ctrl_reg[SIRC_CTRL_NINE] ? 4'hc : 4'hb;
      tx_ph_reg <= 5'h1f;
    end else if (ctrl_reg[SIRC_CTRL_TX_CANCEL] || coll_reg) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 12'hfff;
    end else if (tx_busy_reg && tick32) begin
      tx_ph_reg <= tx_ph_reg + 5'h01;
      if (tx_ph_reg == 5'h1f) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        if (tx_left_reg == 4'h1) tx_busy_reg <= 1'b0;
      end
    end
  end

  // centred pulse window over 32 phases
  always_comb begin
    case (wid)
      SIRC_WID_1_32: tx_level = (tx_ph_reg == 5'h10);
      SIRC_WID_1_16: tx_level = (tx_ph_reg >= 5'h0f) && (tx_ph_reg <= 5'h10);
      SIRC_WID_3_16: tx_level = (tx_ph_reg >= 5'h0d) && (tx_ph_reg <= 5'h12);
      SIRC_WID_1_4: tx_level = (tx_ph_reg >= 5'h0c) && (tx_ph_reg <= 5'h13);
      default: tx_level = 1'b0;
    endcase
  end

  // pulse only for zero bits, polarity inverts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) tx_pin <= 1'b1;
    else if (ir_en)
      tx_pin <= (tx_busy_reg && !tx_sh_reg[0] && tx_level) ^ ctrl_reg[SIRC_CTRL_TX_PULSE_POLARITY];
    else tx_pin <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
  end

  // collision: line seen differs from sent level at mid bit (nrz)
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) coll_reg <= 1'b0;
    else if (!ir_en && tx_busy_reg && tick32 && tx_ph_reg == 5'h10 && rx_pin != tx_sh_reg[0])
      coll_reg <= 1'b1;
    else if (bus_req.wr && bus_req.addr == SIRC_ADDR_STAT && bus_req.wdata[SIRC_STAT_COLL])
      coll_reg <= 1'b0;
  end

  irq_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (full_reg && ctrl_reg[SIRC_CTRL_RIE]) |=> rx_irq) else $error("irq missing");
  frame_full_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    frame_done |=> full_reg) else $error("full not set");
  // data changes only at frame end
  data_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !$past(frame_done) |-> $stable(rx_data_reg)) else $error("data changed");
  tx_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($past(ir_en) && !$past(tx_busy_reg)) |-> tx_pin == $past(ctrl_reg[SIRC_CTRL_TX_PULSE_POLARITY]))
    else $error("ir idle wrong");
  start_hist_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_state_reg == SIRC_RX_IDLE && $past(rx_state_reg) == SIRC_RX_IDLE) ##1
    (rx_state_reg == SIRC_RX_START) |-> $past(hist_reg) == 3'b111) else $error("bad start");
  // eight bit mode clears bit 8
  eight_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (frame_done && !ctrl_reg[SIRC_CTRL_NINE]) |=> !rx_data_reg[8]) else $error("bit8 set");
  pulse_mid_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_level |-> tx_ph_reg >= 5'h0c && tx_ph_reg <= 5'h13) else $error("pulse off centre");
  nrz_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!$past(ir_en) && !$past(tx_busy_reg)) |-> tx_pin) else $error("nrz idle low");
  cov_frame: cover property (@(posedge clk_sys) disable iff (!arst_n) frame_done);
  cov_noise: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(noise_reg));
  cov_ir_tx: cover property (@(posedge clk_sys) disable iff (!arst_n) ir_en && tx_level);
endmodule : sirc_top
`default_nettype wire

// ===== tb/sirc_link_model.sv
// sirc_link_model: far serial node that drives the block's receive line.
// Assumes the bench calls its tasks and a bit time is a whole count of clocks.
`timescale 1ns/100ps
`default_nettype none
module sirc_link_model #(
  parameter int BIT_CLK = 64
) (
  // clock
  input wire logic clk_sys,
  // transmit line of the block, echoed on a shared bus
  input wire logic tx_line,
  // receive line of the block
  output var logic line
);
  localparam int PW = BIT_CLK * 3 / 16;  // 3/16 pulse width
  localparam int TK = BIT_CLK / 16;      // one sample tick

  initial line = 1'b1;

  // hold one level for n clocks, changed just after an edge
  task automatic hold(input logic lv, input int n);
    line <= lv;
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // shared bus: receive line follows the transmit line for n clocks
  task automatic echo(input int n);
    repeat (n) begin
      line <= tx_line;
      @(posedge clk_sys);
    end
  endtask : echo

  // line format: nrz level, or centred pulse of level !pol for zero
  task automatic send_bit(input logic b, input logic ir, input logic pol);
    if (!ir) begin
      hold(b, BIT_CLK);
    end else if (b) begin
      hold(pol, BIT_CLK);
    end else begin
      hold(pol, (BIT_CLK - PW) / 2);
      hold(!pol, PW);
      hold(pol, BIT_CLK - PW - (BIT_CLK - PW) / 2);
    end
  endtask : send_bit

  // frame order: idle, start, lsb first, stop; g > 0 gives a short start
  task automatic send_frame(input logic [8:0] d, input logic nine, input logic ir,
                            input logic pol, input logic stp, input int g);
    int i;
    hold(ir ? pol : 1'b1, 3 * BIT_CLK);
    if (g > 0) begin
      hold(1'b0, g * TK);
      hold(1'b1, BIT_CLK - g * TK);
    end else begin
      send_bit(1'b0, ir, pol);
    end
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      send_bit(d[i], ir, pol);
    end
    send_bit(stp, ir, pol);
    hold(ir ? pol : 1'b1, BIT_CLK);
  endtask : send_frame
endmodule : sirc_link_model
`default_nettype wire

// ===== tb/sirc_top_tb_top.sv
// sirc_top_tb_top: register-level bench for the serial receiver and ir codec.
// Assumes a far node model on the receive line and baud divisor 2 (64 clocks a bit).
`timescale 1ns/100ps
`default_nettype none
module sirc_top_tb_top;
  import sirc_pkg::*;
  localparam int BIT = 64;
  logic clk_sys;
  logic arst_n;
  sirc_bus_req_t bus_req;
  logic [15:0] bus_rdata;
  logic rx_pin;
  logic tx_pin;
  logic rx_irq;
  int bad_count;
  int total_checks;
  logic [15:0] v;
  int n;
  int i;
  logic [8:0] d;
  int wid [4];

  sirc_top sirc_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_irq(rx_irq));
  sirc_link_model #(.BIT_CLK(BIT)) sirc_link_model_inst (.clk_sys(clk_sys), .tx_line(tx_pin),
    .line(rx_pin));

  // clock
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, dat};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] dat);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 dat = bus_rdata;
  endtask : rd

  // control word builder, receiver enabled
  function automatic logic [15:0] ctl(input logic ir, input logic txp, input logic rxp,
                                      input logic nine, input logic rx_full_irq_enable, input logic [1:0] w);
    return 16'h0100 | (16'(ir) << SIRC_CTRL_IR_EN) | (16'(txp) << SIRC_CTRL_TX_PULSE_POLARITY)
      | (16'(rxp) << SIRC_CTRL_RX_PULSE_POLARITY) | (16'(nine) << SIRC_CTRL_NINE)
      | (16'(rx_full_irq_enable) << SIRC_CTRL_RIE) | (16'(w) << SIRC_CTRL_WID_LO);
  endfunction : ctl

  // change mode with the receiver off while the line settles to its idle level
  task automatic cfg(input logic [15:0] c, input logic idle);
    wr(SIRC_ADDR_CTRL, c & ~(16'h0001 << SIRC_CTRL_RX_EN));
    sirc_link_model_inst.hold(idle, 8);
    wr(SIRC_ADDR_CTRL, c);
  endtask : cfg

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    results();
  end

  // main sequence
  initial begin
    bus_req = '0;
    arst_n = 1'b0;
    bad_count = 0;
    total_checks = 0;
    wid = '{BIT / 32, BIT / 16, 3 * BIT / 16, BIT / 4};
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(SIRC_ADDR_CTRL, v);
    check(v, 16'(SIRC_CTRL_RST));
    rd(SIRC_ADDR_BAUD, v);
    check(v, SIRC_BAUD_RST);
    wr(4'hf, 16'hffff);
    rd(4'hf, v);
    check(v, 16'h0000);
    wr(SIRC_ADDR_BAUD, 16'h0002);
    rd(SIRC_ADDR_BAUD, v);
    check(v, 16'h0002);
    // eight-bit nrz frame, interrupt masked
    sirc_link_model_inst.send_frame(9'h0a5, 1'b0, 1'b0, 1'b0, 1'b1, 0);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0007, 16'h0001);
    check({15'h0000, rx_irq}, 16'h0000);
    rd(SIRC_ADDR_DATA, v);
    check(v, 16'h00a5);
    wr(SIRC_ADDR_DATA, 16'h01ff);
    rd(SIRC_ADDR_DATA, v);
    check(v, 16'h00a5);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0001, 16'h0000);
    // nine-bit frame with interrupt enabled
    cfg(ctl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0), 1'b1);
    sirc_link_model_inst.send_frame(9'h1c3, 1'b1, 1'b0, 1'b0, 1'b1, 0);
    check({15'h0000, rx_irq}, 16'h0001);
    rd(SIRC_ADDR_DATA, v);
    check(v, 16'h01c3);
    repeat (2) @(posedge clk_sys);
    #1 check({15'h0000, rx_irq}, 16'h0000);
    // short start of six ticks: accepted with noise
    cfg(ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0), 1'b1);
    sirc_link_model_inst.send_frame(9'h03c, 1'b0, 1'b0, 1'b0, 1'b1, 6);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0007, 16'h0003);
    rd(SIRC_ADDR_DATA, v);
    check(v, 16'h003c);
    wr(SIRC_ADDR_STAT, 16'h0002);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0007, 16'h0000);
    // two-tick glitch: start rejected, nothing received
    sirc_link_model_inst.send_frame(9'h0ff, 1'b0, 1'b0, 1'b0, 1'b1, 2);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0007, 16'h0000);
    // all-zero frame including stop is a break
    sirc_link_model_inst.send_frame(9'h000, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0005, 16'h0005);
    rd(SIRC_ADDR_DATA, v);
    check(v, 16'h0000);
    wr(SIRC_ADDR_STAT, 16'h0004);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0007, 16'h0000);
    // ir receive with both pulse polarities
    for (i = 0; i < 2; i++) begin
      d = (i == 1) ? 9'h0c6 : 9'h05a;
      cfg(ctl(1'b1, 1'b0, i[0], 1'b0, 1'b0, 2'h2), i[0]);
      sirc_link_model_inst.send_frame(d, 1'b0, 1'b1, i[0], 1'b1, 0);
      rd(SIRC_ADDR_STAT, v);
      check(v & 16'h0007, 16'h0001);
      rd(SIRC_ADDR_DATA, v);
      check(v, 16'(d));
    end
    // transmit 0x00: nine zero bits; four ir widths, both polarities, then nrz
    for (i = 0; i < 5; i++) begin
      cfg(ctl(i < 4, i[0], 1'b0, 1'b0, 1'b0, i[1:0]), i == 4);
      wr(SIRC_ADDR_TXD, 16'h0000);
      n = 0;
      fork
        if (i == 4) sirc_link_model_inst.echo(11 * BIT);
        repeat (11 * BIT) begin
          @(posedge clk_sys);
          if (tx_pin === ((i < 4) ? !i[0] : 1'b0)) n++;
        end
      join
      check(16'(n), 16'((i < 4) ? 9 * wid[i] : 9 * BIT));
    end
    // nrz send against a line held high: collision stops the frame
    wr(SIRC_ADDR_TXD, 16'h0000);
    repeat (2 * BIT) @(posedge clk_sys);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0018, 16'h0008);
    wr(SIRC_ADDR_STAT, 16'h0008);
    // busy frame dropped by the cancel control
    wr(SIRC_ADDR_TXD, 16'h0000);
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0018, 16'h0010);
    wr(SIRC_ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0) | (16'h0001 << SIRC_CTRL_TX_CANCEL));
    rd(SIRC_ADDR_STAT, v);
    check(v & 16'h0018, 16'h0000);
    results();
  end
endmodule : sirc_top_tb_top
`default_nettype wire
